// ---- rtl/emacc_dev.sv ----
// Summary of operation
// - frame: preamble, start, op, addresses, TA, data
// - op 10 with select 11 reads
// - op 01 with select 11 writes
// - address is phy[4:3], phy[0], reg field
// - read TA: master floats, device drives zero
// - write TA: master sends one then zero
// - read returns zero high byte, register low
// - write stores low byte, ignores high
// - every register eight bits wide
// - all 256 addresses reachable
// - standard MII registers reachable indirectly
// - management clock at most 10 MHz
// - otherwise standard clause-22 timing and order
// - port blocks decoded at 0x10 steps
// - port gap 0x15-0x17 is factory test
// - self-test control register at 0x88
// - power-down control at 0x0E-0x0F
// - start 01, read 10, write 01, idle floats
`include "emacc_defines.svh"
module emacc_dev
  import emacc_pkg::*;
#(
  parameter int NREG = 256
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  emacc_if.dev       link,
  output logic       wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output emacc_area_t wr_area,
  output logic [7:0] selftest_ctrl,
  output logic [7:0] pwr_ctrl
);
  typedef struct packed {
    emacc_state_t st;
    emacc_kind_t  kind;
    logic [5:0]   cnt;
    logic [13:0]  hdr;
    logic [15:0]  sh;
    logic         mdc_d;
    logic         mo;
    logic         moe_n;
    logic         stb;
    logic [7:0]   addr;
    logic [7:0]   data;
  } emacc_dstate_t;
  emacc_dstate_t s_reg, s_next;
  logic [7:0] regs [NREG];
  logic       mdc_s;
  logic       mdio_s;
  logic       rise;
  logic       fall;
  function automatic logic [7:0] emacc_addr(input logic [4:0] phy,
                                             input logic [4:0] rg);
    return {phy[4:3], phy[0], rg};
  endfunction : emacc_addr
  function automatic emacc_area_t emacc_area(input logic [7:0] a);
    emacc_area_t r;
    r = EMACC_AREA_USER;
    if (a >= `EMACC_PORT_BASE &&
        a < `EMACC_PORT_BASE + `EMACC_PORT_STEP * 8'(`EMACC_PORT_CNT) &&
        a[3:0] >= `EMACC_RSV_LO && a[3:0] <= `EMACC_RSV_HI)
      r = EMACC_AREA_RSV;
    if (a >= `EMACC_MII_BASE &&
        (a - `EMACC_MII_BASE <= `EMACC_MII_HI ||
         a - `EMACC_MII_BASE == `EMACC_MII_29 ||
         a - `EMACC_MII_BASE == `EMACC_MII_31))
      r = EMACC_AREA_MII;
    return r;
  endfunction : emacc_area
  emacc_sync #(
    .INIT (1'b0)
  ) u_sync_mdc (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.mdc),
    .q      (mdc_s)
  );
  emacc_sync u_sync_mdio (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.mdio_line),
    .q      (mdio_s)
  );
  // sample on mdc rising, drive on falling
  assign rise = mdc_s && !s_reg.mdc_d;
  assign fall = !mdc_s && s_reg.mdc_d;
  always_comb begin
    s_next = s_reg;
    s_next.mdc_d = mdc_s;
    s_next.stb = 1'b0;
    if (rise) begin
      case (s_reg.st)
        EMACC_IDLE: begin
          s_next.cnt = mdio_s ? 6'd1 : 6'd0;
          if (mdio_s) s_next.st = EMACC_PRE;
        end
        EMACC_PRE: begin
          if (mdio_s) begin
            if (s_reg.cnt < `EMACC_PRE_LEN) s_next.cnt = s_reg.cnt + 6'd1;
          end else if (s_reg.cnt >= `EMACC_PRE_LEN) begin
            s_next.st = EMACC_HDR;
            // the opening start bit is the first header bit
            s_next.cnt = 6'd1;
            s_next.hdr = {13'h0, mdio_s};
          end else begin
            s_next.st = EMACC_IDLE;
          end
        end
        EMACC_HDR: begin
          s_next.hdr = {s_reg.hdr[12:0], mdio_s};
          s_next.cnt = s_reg.cnt + 6'd1;
          if (s_reg.cnt == 6'(`EMACC_HDR_LEN - 5'd1)) begin
            s_next.st = EMACC_TA;
            s_next.cnt = 6'd0;
            s_next.kind = EMACC_KIND_NONE;
            s_next.addr = emacc_addr(s_next.hdr[9:5], s_next.hdr[4:0]);
            if (s_next.hdr[13:12] == `EMACC_ST_CODE &&
                s_next.hdr[7:6] == `EMACC_SEL_BITS) begin
              if (s_next.hdr[11:10] == `EMACC_OP_RD)
                s_next.kind = EMACC_KIND_RD;
              if (s_next.hdr[11:10] == `EMACC_OP_WR)
                s_next.kind = EMACC_KIND_WR;
            end
            s_next.sh = {8'h00, regs[s_next.addr]};
          end
        end
        EMACC_TA: begin
          s_next.cnt = s_reg.cnt + 6'd1;
          if (s_reg.cnt == 6'd1) begin
            s_next.st = EMACC_DATA;
            s_next.cnt = 6'd0;
          end
        end
        EMACC_DATA: begin
          s_next.cnt = s_reg.cnt + 6'd1;
          if (s_reg.kind != EMACC_KIND_RD)
            s_next.sh = {s_reg.sh[14:0], mdio_s};
          if (s_reg.cnt == 6'(`EMACC_DATA_LEN - 5'd1)) begin
            s_next.st = EMACC_END;
            if (s_reg.kind == EMACC_KIND_WR) begin
              s_next.stb = 1'b1;
              s_next.data = s_next.sh[7:0];
            end
          end
        end
        default: begin
          s_next.st = EMACC_IDLE;
        end
      endcase
    end
    if (fall) begin
      // drive zero in second TA bit
      if (s_reg.st == EMACC_TA && s_reg.cnt == 6'd1 &&
          s_reg.kind == EMACC_KIND_RD) begin
        s_next.moe_n = 1'b0;
        s_next.mo = 1'b0;
      end else if (s_reg.st == EMACC_DATA && s_reg.kind == EMACC_KIND_RD) begin
        s_next.moe_n = 1'b0;
        s_next.mo = s_reg.sh[15];
        s_next.sh = {s_reg.sh[14:0], 1'b0};
      end else begin
        s_next.moe_n = 1'b1;
        s_next.mo = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '{st: EMACC_IDLE, kind: EMACC_KIND_NONE, mdc_d: 1'b0,
                 moe_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NREG; i++) regs[i] <= 8'h00;
    end else if (s_reg.stb) begin
      regs[s_reg.addr] <= s_reg.data;
    end
  end
  assign link.mdio_s_o = s_reg.mo;
  assign link.mdio_s_oe_n = s_reg.moe_n;
  assign wr_stb = s_reg.stb;
  assign wr_addr = s_reg.addr;
  assign wr_data = s_reg.data;
  assign wr_area = emacc_area(s_reg.addr);
  assign selftest_ctrl = regs[`EMACC_SELFTEST];
  assign pwr_ctrl = regs[`EMACC_PWR_LO] | regs[`EMACC_PWR_HI];
endmodule : emacc_dev

// ---- rtl/emacc_defines.svh ----
`ifndef EMACC_DEFINES_SVH
`define EMACC_DEFINES_SVH
`define EMACC_PRE_LEN      6'd32
`define EMACC_ST_CODE      2'b01
`define EMACC_OP_RD        2'b10
`define EMACC_OP_WR        2'b01
`define EMACC_TA_WR        2'b10
`define EMACC_SEL_BITS     2'b11
`define EMACC_DATA_LEN     5'd16
`define EMACC_HDR_LEN      5'd14
`define EMACC_IDLE_LEN     5'd2
`define EMACC_PWR_LO       8'h0E
`define EMACC_PWR_HI       8'h0F
`define EMACC_SELFTEST     8'h88
`define EMACC_PORT_BASE    8'h10
`define EMACC_PORT_STEP    8'h10
`define EMACC_PORT_CNT     3'd5
`define EMACC_RSV_LO       4'h5
`define EMACC_RSV_HI       4'h7
`define EMACC_MII_HI       8'h05
`define EMACC_MII_29       8'h1D
`define EMACC_MII_31       8'h1F
`define EMACC_MII_BASE     8'hE0
`define EMACC_FRAME_BITS   7'd64
`endif

// ---- rtl/emacc_pkg.sv ----
package emacc_pkg;
  typedef enum logic [2:0] {
    EMACC_IDLE, EMACC_PRE, EMACC_HDR, EMACC_TA, EMACC_DATA, EMACC_END
  } emacc_state_t;
  typedef enum logic [1:0] {
    EMACC_KIND_NONE, EMACC_KIND_RD, EMACC_KIND_WR
  } emacc_kind_t;
  typedef enum logic [1:0] {
    EMACC_M_IDLE, EMACC_M_BUSY, EMACC_M_LOW
  } emacc_mstate_t;
  typedef enum logic [1:0] {
    EMACC_AREA_USER, EMACC_AREA_RSV, EMACC_AREA_MII
  } emacc_area_t;
endpackage : emacc_pkg

// ---- rtl/emacc_if.sv ----
interface emacc_if;
  logic mdc;
  logic mdio_m_o;
  logic mdio_m_oe_n;
  logic mdio_s_o;
  logic mdio_s_oe_n;
  wire  mdio_line;
  assign mdio_line = !mdio_m_oe_n ? mdio_m_o :
                     !mdio_s_oe_n ? mdio_s_o : 1'b1;
  modport ctrl (output mdc, output mdio_m_o, output mdio_m_oe_n,
                input mdio_line);
  modport dev  (input mdc, output mdio_s_o, output mdio_s_oe_n,
                input mdio_line);
endinterface : emacc_if

// ---- rtl/emacc_sync.sv ----
module emacc_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);
  logic [1:0] s_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // start at the pin's idle level so no false edge follows reset
      s_reg <= {2{INIT}};
    end else begin
      s_reg <= {s_reg[0], d};
    end
  end
  assign q = s_reg[1];
endmodule : emacc_sync

// ---- rtl/emacc_ctrl.sv ----
`include "emacc_defines.svh"
module emacc_ctrl
  import emacc_pkg::*;
#(
  parameter int DIV = 13
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  emacc_if.ctrl      link,
  input  wire logic  req,
  input  wire logic  req_wr,
  input  wire logic [4:0] req_phy,
  input  wire logic [4:0] req_reg,
  input  wire logic [15:0] req_wdata,
  output logic       busy,
  output logic       done,
  output logic [15:0] rdata
);
  localparam int FLEN = 64 + 2;
  typedef struct packed {
    emacc_mstate_t st;
    logic [7:0]    div;
    logic          mdc;
    logic [6:0]    bit_i;
    logic [63:0]   sh;
    logic [63:0]   oen;
    logic [15:0]   rd;
    logic          done;
  } emacc_cstate_t;
  emacc_cstate_t c_reg, c_next;
  logic mdio_s;
  emacc_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (link.mdio_line),
    .q      (mdio_s)
  );
  always_comb begin
    c_next = c_reg;
    c_next.done = 1'b0;
    case (c_reg.st)
      EMACC_M_IDLE: begin
        if (req) begin
          c_next.st = EMACC_M_BUSY;
          c_next.sh = {32'hFFFF_FFFF, `EMACC_ST_CODE,
                       req_wr ? `EMACC_OP_WR : `EMACC_OP_RD, req_phy,
                       req_reg, `EMACC_TA_WR, req_wdata};
          c_next.oen = req_wr ? 64'h0 : 64'h0000_0000_0003_FFFF;
          c_next.bit_i = '0;
          c_next.div = '0;
          c_next.mdc = 1'b0;
        end
      end
      EMACC_M_BUSY: begin
        c_next.div = c_reg.div + 8'd1;
        if (c_reg.div == 8'(DIV - 1)) begin
          c_next.div = '0;
          c_next.mdc = !c_reg.mdc;
          if (c_reg.mdc) begin
            c_next.sh = {c_reg.sh[62:0], 1'b1};
            c_next.oen = {c_reg.oen[62:0], 1'b1};
            c_next.bit_i = c_reg.bit_i + 7'd1;
            if (c_reg.bit_i == 7'(FLEN - 1)) c_next.st = EMACC_M_LOW;
          end else if (c_reg.bit_i < `EMACC_FRAME_BITS) begin
            // idle bits must not push data out
            c_next.rd = {c_reg.rd[14:0], mdio_s};
          end
        end
      end
      default: begin
        c_next.st = EMACC_M_IDLE;
        c_next.done = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      c_reg <= '{st: EMACC_M_IDLE, oen: '1, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end
  assign link.mdc = c_reg.mdc;
  assign link.mdio_m_o = c_reg.sh[63];
  assign link.mdio_m_oe_n = c_reg.oen[63] || c_reg.st != EMACC_M_BUSY ||
                            c_reg.bit_i >= `EMACC_FRAME_BITS;
  assign busy = c_reg.st != EMACC_M_IDLE;
  assign done = c_reg.done;
  assign rdata = c_reg.rd;
endmodule : emacc_ctrl

// ---- verification/emacc_link_checker.sv ----
module emacc_link_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_m_o,
  input wire logic mdio_m_oe_n,
  input wire logic mdio_s_o,
  input wire logic mdio_s_oe_n,
  input wire logic mdio_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [6:0] quiet_reg;
  always_ff @(posedge clk) begin
    if (!resetn || $changed(mdc)) quiet_reg <= 7'h00;
    else if (quiet_reg != 7'h7F) quiet_reg <= quiet_reg + 7'h01;
  end
  no_contend_a: assert property (!mdio_m_oe_n |-> mdio_s_oe_n)
    else $error("both ends drive the data line");
  ta_zero_a: assert property ($fell(mdio_s_oe_n) |-> !mdio_line)
    else $error("turnaround answer not zero");
  mdc_high_a: assert property ($rose(mdc) |=> mdc [*8])
    else $error("mdc high phase too short");
  mdc_low_a: assert property ($fell(mdc) |=> !mdc [*8])
    else $error("mdc low phase too short");
  rd_span_a: assert property ($fell(mdio_s_oe_n) |->
    ##200 !mdio_s_oe_n ##200 !mdio_s_oe_n ##[1:140] mdio_s_oe_n)
    else $error("read data span wrong length");
  m_change_a: assert property (!mdio_m_oe_n && $past(!mdio_m_oe_n) &&
    $changed(mdio_m_o) |-> !mdc) else $error("master changed at mdc high");
  s_change_a: assert property (!mdio_s_oe_n && $past(!mdio_s_oe_n) &&
    $changed(mdio_s_o) |-> !mdc) else $error("device changed at mdc high");
  quiet_a: assert property (quiet_reg > 7'd60 |-> mdio_s_oe_n)
    else $error("device drives while link idle");
  cover property ($fell(mdio_s_oe_n));
  cover property ($rose(mdc));
  cover property (quiet_reg == 7'd61);
endmodule : emacc_link_checker

// ---- verification/emacc_test.sv ----
module emacc_test
  import emacc_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, req, req_wr, busy, done, wr_stb, stb_seen;
  logic [4:0]  req_phy, req_reg;
  logic [15:0] req_wdata, rdata;
  logic [7:0]  wr_addr, wr_data, selftest_ctrl, pwr_ctrl, stb_addr, stb_data;
  emacc_area_t wr_area, stb_area;
  int          mismatches, cmp_count, cyc;
  emacc_if lnk();
  emacc_ctrl i_emacc_ctrl (.clk(clk), .resetn(resetn), .link(lnk),
    .req(req), .req_wr(req_wr), .req_phy(req_phy), .req_reg(req_reg),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
  emacc_dev i_emacc_dev (.clk(clk), .resetn(resetn), .link(lnk),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_area(wr_area), .selftest_ctrl(selftest_ctrl), .pwr_ctrl(pwr_ctrl));
  emacc_link_checker i_emacc_link_checker (.clk(clk), .resetn(resetn),
    .mdc(lnk.mdc), .mdio_m_o(lnk.mdio_m_o), .mdio_m_oe_n(lnk.mdio_m_oe_n),
    .mdio_s_o(lnk.mdio_s_o), .mdio_s_oe_n(lnk.mdio_s_oe_n),
    .mdio_line(lnk.mdio_line));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      stb_seen <= 1'b1;
      stb_addr <= wr_addr;
      stb_data <= wr_data;
      stb_area <= wr_area;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [4:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd);
    int n;
    stb_seen = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    req_wr <= wr;
    req_phy <= phy;
    req_reg <= rg;
    req_wdata <= wd;
    n = 0;
    do begin @(negedge clk); n++; end while (busy !== 1'b1 && n < 50);
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 4000);
    chk({15'h0, done}, 16'h0001);
    n = 0;
    while (wr && stb_seen !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask : xfer
  task automatic wr8(input logic [7:0] a, input logic [15:0] d,
                     input emacc_area_t ar);
    xfer(1'b1, {a[7:6], 2'b11, a[5]}, a[4:0], d);
    chk({15'h0, stb_seen}, 16'h0001);
    chk({8'h00, stb_addr}, {8'h00, a});
    chk({8'h00, stb_data}, {8'h00, d[7:0]});
    chk(16'(stb_area), 16'(ar));
  endtask : wr8
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, {a[7:6], 2'b11, a[5]}, a[4:0], 16'h0000);
    chk(rdata, {8'h00, e});
  endtask : rd8
  task automatic t_rw();
    wr8(8'hA5, 16'hFF3C, EMACC_AREA_USER);
    wr8(8'h5A, 16'h00C3, EMACC_AREA_USER);
    rd8(8'hA5, 8'h3C);
    rd8(8'h5A, 8'hC3);
  endtask : t_rw
  task automatic t_edges();
    rd8(8'hFF, 8'h00);
    wr8(8'h00, 16'h5A81, EMACC_AREA_USER);
    rd8(8'h00, 8'h81);
    wr8(8'h88, 16'h0077, EMACC_AREA_USER);
    chk({8'h00, selftest_ctrl}, 16'h0077);
    wr8(8'h0E, 16'h0011, EMACC_AREA_USER);
    wr8(8'h0F, 16'h0082, EMACC_AREA_USER);
    chk({8'h00, pwr_ctrl}, 16'h0093);
  endtask : t_edges
  task automatic t_area();
    wr8(8'h14, 16'h0001, EMACC_AREA_USER);
    wr8(8'h15, 16'h0002, EMACC_AREA_RSV);
    wr8(8'h57, 16'h0003, EMACC_AREA_RSV);
    wr8(8'hE1, 16'h0004, EMACC_AREA_MII);
    wr8(8'hFD, 16'h0006, EMACC_AREA_MII);
    wr8(8'hF1, 16'h0008, EMACC_AREA_USER);
  endtask : t_area
  task automatic t_unsel();
    xfer(1'b0, 5'b00010, 5'h03, 16'h0000);
    chk(rdata, 16'hFFFF);
    xfer(1'b1, 5'b11001, 5'h03, 16'h00AA);
    chk({15'h0, stb_seen}, 16'h0000);
  endtask : t_unsel
  initial begin
    resetn = 1'b0;
    req = 1'b0;
    req_wr = 1'b0;
    req_phy = 5'h00;
    req_reg = 5'h00;
    req_wdata = 16'h0000;
    stb_seen = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_rw();
    t_edges();
    t_area();
    t_unsel();
    test_done();
  end
endmodule : emacc_test
